/* File: rtl/mlt_defines.svh */
`ifndef MLT_DEFINES_SVH
`define MLT_DEFINES_SVH
// table geometry
`define MLT_AW 13
`define MLT_DEPTH 14'h2000
`define MLT_LAST 13'h1fff
`define MLT_PW 2
`define MLT_PORTS 4
// limits
`define MLT_STATIC_MAX 5'h1e
`define MLT_AGE_MAX 12'hef1
`define MLT_AGE_OFF 12'h000
// one aging tick is one second at the 125 MHz clock
`define MLT_CLK_HZ 125000000
`define MLT_TICK_S 1
// address classes
`define MLT_BCAST 48'hffffffffffff
`define MLT_GRP_BIT 40
`endif

/* File: rtl/mlt_fwd_table.sv */
`timescale 1ns/1ns
`include "mlt_defines.svh"
module mlt_fwd_table #(
  parameter int unsigned CYC_PER_SEC = `MLT_CLK_HZ * `MLT_TICK_S
) (
  // clock and reset
  input logic clock,
  input logic rst,
  // lookup request
  input logic lk_valid,
  output logic lk_ready,
  input logic [47:0] lk_dst,
  input logic [47:0] lk_src,
  input logic [11:0] lk_vlan,
  input logic [`MLT_PW-1:0] lk_port,
  // lookup result
  output logic res_valid,
  output mlt_pkg::mlt_act_t res_act,
  output logic [`MLT_PORTS-1:0] res_mask,
  // management
  input logic mg_valid,
  output logic mg_ready,
  input mlt_pkg::mlt_mg_op_t mg_op,
  input logic [47:0] mg_mac,
  input logic [11:0] mg_vlan,
  input logic [`MLT_PW-1:0] mg_port,
  output logic mg_done,
  output logic mg_ok,
  // configuration
  input logic learn_en,
  input logic [11:0] age_time,
  input logic [13:0] learn_limit,
  input logic card_rst,
  // status
  output logic busy,
  output logic [13:0] dyn_count,
  output logic [4:0] static_count
);
  typedef enum logic [2:0] {
    S_FL_RD,
    S_FL_CHK,
    S_IDLE,
    S_DST_CHK,
    S_SRC_CHK,
    S_MG_CHK,
    S_AG_CHK
  } mlt_state_t;

  mlt_state_t state_reg, state_next;
  mlt_mem_if mem ();
  mlt_pkg::mlt_entry_t rd;
  mlt_pkg::mlt_entry_t ent_clr;
  mlt_pkg::mlt_entry_t ent_learn;
  mlt_pkg::mlt_entry_t ent_static;

  logic [`MLT_AW-1:0] addr_reg;
  logic [`MLT_AW-1:0] age_ptr_reg;
  logic [47:0] dst_reg;
  logic [47:0] src_reg;
  logic [11:0] vlan_reg;
  logic [`MLT_PW-1:0] in_reg;
  mlt_pkg::mlt_mg_op_t op_reg;
  logic flush_pend_reg;
  logic [31:0] tick_reg;
  logic [11:0] now_reg;
  logic [13:0] dyn_reg;
  logic [4:0] st_reg;

  function automatic logic [`MLT_AW-1:0] hash(input logic [47:0] m, input logic [11:0] v);
    hash = m[12:0] ^ m[25:13] ^ m[38:26] ^ {4'h0, m[47:39]} ^ {1'h0, v};
  endfunction

  mlt_table_ram u_ram (
    .clock(clock),
    .m(mem)
  );

  assign rd = mem.rdata;

  // request arbitration in idle: flush, then management, then lookup, then aging
  wire idle = state_reg == S_IDLE;
  wire take_fl = idle && flush_pend_reg;
  wire take_mg = idle && !flush_pend_reg && mg_valid;
  wire take_lk = idle && !flush_pend_reg && !mg_valid && lk_valid;
  assign mg_ready = idle && !flush_pend_reg;
  assign lk_ready = idle && !flush_pend_reg && !mg_valid;
  assign busy = state_reg == S_FL_RD || state_reg == S_FL_CHK;
  assign dyn_count = dyn_reg;
  assign static_count = st_reg;

  // keys
  wire [`MLT_AW-1:0] h_lk = hash(lk_dst, lk_vlan);
  wire [`MLT_AW-1:0] h_mg = hash(mg_mac, mg_vlan);
  wire [`MLT_AW-1:0] h_src = hash(src_reg, vlan_reg);
  wire [`MLT_AW-1:0] idle_addr = take_mg ? h_mg : (take_lk ? h_lk : age_ptr_reg);

  // destination classification
  wire d_hit = rd.valid && rd.mac == dst_reg && rd.vlan == vlan_reg;
  wire d_bcast = dst_reg == `MLT_BCAST;
  wire d_grp = dst_reg[`MLT_GRP_BIT] && !d_bcast;
  wire [`MLT_PORTS-1:0] hit_mask = `MLT_PORTS'(1) << rd.port;
  wire [`MLT_PORTS-1:0] flood_mask = ~(`MLT_PORTS'(1) << in_reg);

  // source learning
  wire s_hit = rd.valid && rd.mac == src_reg && rd.vlan == vlan_reg;
  wire s_ok = !src_reg[`MLT_GRP_BIT];
  wire [13:0] lim_eff = learn_limit < `MLT_DEPTH ? learn_limit : `MLT_DEPTH;
  wire room = dyn_reg < lim_eff;
  wire s_refresh = state_reg == S_SRC_CHK && s_ok && s_hit && !rd.is_static;
  wire s_insert = state_reg == S_SRC_CHK && s_ok && !rd.valid && learn_en && room;

  // management
  wire m_match = rd.valid && rd.mac == src_reg && rd.vlan == vlan_reg;
  wire st_room = st_reg < `MLT_STATIC_MAX;
  wire m_chk = state_reg == S_MG_CHK;
  wire m_keep = m_match && rd.is_static;
  wire m_new = (!rd.valid || !rd.is_static) && st_room;
  wire m_add = m_chk && op_reg == mlt_pkg::MG_ADD && (m_keep || m_new);
  wire m_del = m_chk && op_reg == mlt_pkg::MG_DEL && m_keep;
  wire m_evict = m_add && !m_keep && rd.valid;

  // aging
  wire [11:0] age_eff = age_time > `MLT_AGE_MAX ? `MLT_AGE_MAX : age_time;
  wire [11:0] age_diff = now_reg - rd.stamp;
  wire ag_del = state_reg == S_AG_CHK && rd.valid && !rd.is_static
    && age_eff != `MLT_AGE_OFF && age_diff >= age_eff;

  // flush after restart or card reset
  wire fl_chk = state_reg == S_FL_CHK;
  wire fl_st = fl_chk && rd.valid && rd.is_static;
  wire fl_last = fl_chk && addr_reg == `MLT_LAST;

  // counters
  wire dyn_inc = s_insert;
  wire dyn_dec = ag_del || m_evict;
  wire st_inc = (m_add && !m_keep) || fl_st;
  wire st_dec = m_del;

  // entry images
  always_comb
  begin
    ent_clr = '0;
    ent_learn.valid = 1'b1;
    ent_learn.is_static = 1'b0;
    ent_learn.mac = src_reg;
    ent_learn.vlan = vlan_reg;
    ent_learn.port = in_reg;
    ent_learn.stamp = now_reg;
    ent_static = ent_learn;
    ent_static.is_static = 1'b1;
    ent_static.port = op_reg == mlt_pkg::MG_ADD ? dst_reg[`MLT_PW-1:0] : in_reg;
  end

  // table port
  always_comb
  begin
    mem.addr = addr_reg;
    mem.we = 1'b0;
    mem.wdata = ent_clr;
    if (idle)
    begin
      mem.addr = idle_addr;
    end
    else if (state_reg == S_DST_CHK)
    begin
      mem.addr = h_src;
    end
    if (s_refresh || s_insert)
    begin
      mem.we = 1'b1;
      mem.wdata = ent_learn;
    end
    else if (m_add)
    begin
      mem.we = 1'b1;
      mem.wdata = ent_static;
    end
    else if (m_del || ag_del)
    begin
      mem.we = 1'b1;
    end
    else if (fl_chk)
    begin
      // anything not a proven static is cleared, so an unset table comes out empty
      if (fl_st)
      begin
        mem.we = 1'b0;
      end
      else
      begin
        mem.we = 1'b1;
      end
    end
  end

  // next state
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      S_FL_RD: state_next = S_FL_CHK;
      S_FL_CHK: state_next = fl_last ? S_IDLE : S_FL_RD;
      S_IDLE:
      begin
        if (take_fl)
        begin
          state_next = S_FL_RD;
        end
        else if (take_mg)
        begin
          state_next = S_MG_CHK;
        end
        else if (take_lk)
        begin
          state_next = S_DST_CHK;
        end
        else
        begin
          state_next = S_AG_CHK;
        end
      end
      S_DST_CHK: state_next = S_SRC_CHK;
      S_SRC_CHK: state_next = S_IDLE;
      S_MG_CHK: state_next = S_IDLE;
      S_AG_CHK: state_next = S_IDLE;
    endcase
  end

  // sequencing and addresses
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= S_FL_RD;
      addr_reg <= '0;
      age_ptr_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      if (take_fl || fl_chk)
      begin
        addr_reg <= take_fl ? '0 : addr_reg + `MLT_AW'(1);
      end
      else if (idle)
      begin
        addr_reg <= idle_addr;
      end
      else if (state_reg == S_DST_CHK)
      begin
        addr_reg <= h_src;
      end
      if (state_reg == S_AG_CHK)
      begin
        age_ptr_reg <= age_ptr_reg + `MLT_AW'(1);
      end
    end
  end

  // request capture; management reuses the source key registers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      dst_reg <= '0;
      src_reg <= '0;
      vlan_reg <= '0;
      in_reg <= '0;
      op_reg <= mlt_pkg::MG_ADD;
    end
    else if (take_lk)
    begin
      dst_reg <= lk_dst;
      src_reg <= lk_src;
      vlan_reg <= lk_vlan;
      in_reg <= lk_port;
    end
    else if (take_mg)
    begin
      dst_reg <= {46'h0, mg_port};
      src_reg <= mg_mac;
      vlan_reg <= mg_vlan;
      op_reg <= mg_op;
    end
  end

  // pending card reset: a new pulse wins over the clear at flush start
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      flush_pend_reg <= 1'b0;
    end
    else
    begin
      flush_pend_reg <= card_rst || (flush_pend_reg && !take_fl);
    end
  end

  // seconds timebase for aging
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      tick_reg <= '0;
      now_reg <= '0;
    end
    else if (tick_reg == CYC_PER_SEC - 1)
    begin
      tick_reg <= '0;
      now_reg <= now_reg + 12'h001;
    end
    else
    begin
      tick_reg <= tick_reg + 32'h1;
    end
  end

  // occupancy; a flush recounts statics from the table
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      dyn_reg <= '0;
      st_reg <= '0;
    end
    else if (take_fl || busy && state_reg == S_FL_RD && addr_reg == '0)
    begin
      dyn_reg <= '0;
      st_reg <= '0;
    end
    else
    begin
      dyn_reg <= dyn_reg + 14'(dyn_inc) - 14'(dyn_dec);
      if (st_inc)
      begin
        st_reg <= st_reg + 5'h01;
      end
      else if (st_dec)
      begin
        st_reg <= st_reg - 5'h01;
      end
    end
  end

  // results
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      res_valid <= 1'b0;
      res_act <= mlt_pkg::ACT_DROP;
      res_mask <= '0;
      mg_done <= 1'b0;
      mg_ok <= 1'b0;
    end
    else
    begin
      res_valid <= state_reg == S_DST_CHK;
      mg_done <= m_chk;
      mg_ok <= m_add || m_del;
      if (state_reg == S_DST_CHK)
      begin
        if (d_bcast || (!d_grp && !d_hit))
        begin
          res_act <= mlt_pkg::ACT_FLOOD;
          res_mask <= flood_mask;
        end
        else if (d_grp)
        begin
          res_act <= d_hit ? mlt_pkg::ACT_MCAST : mlt_pkg::ACT_DROP;
          res_mask <= d_hit ? hit_mask : '0;
        end
        else
        begin
          res_act <= mlt_pkg::ACT_UNI;
          res_mask <= hit_mask;
        end
      end
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_lookup_latency: assert property (lk_valid && lk_ready |-> ##2 res_valid)
    else $error("lookup result not two cycles after accept");
  a_unicast_onehot: assert property (res_valid && res_act == mlt_pkg::ACT_UNI
    |-> $onehot(res_mask))
    else $error("unicast result not a single port");
  a_flood_ingress: assert property (res_valid && res_act == mlt_pkg::ACT_FLOOD
    |-> !res_mask[in_reg] && $countones(res_mask) == `MLT_PORTS - 1)
    else $error("flood mask wrong");
  a_mcast_miss: assert property (state_reg == S_DST_CHK && d_grp && !d_hit
    |=> res_act == mlt_pkg::ACT_DROP && res_mask == '0)
    else $error("multicast miss not discarded");
  a_static_cap: assert property (st_reg <= `MLT_STATIC_MAX)
    else $error("static count above cap");
  a_learn_gate: assert property (s_insert |-> learn_en && dyn_reg < lim_eff
    ##1 dyn_reg == $past(dyn_reg) + 14'h1)
    else $error("learning outside enable or limit");
  a_limit_hold: assert property (dyn_reg >= lim_eff && !take_fl |=> dyn_reg <= $past(dyn_reg))
    else $error("learned count grew past limit");
  a_age_dynamic: assert property (ag_del |-> !rd.is_static && age_eff != `MLT_AGE_OFF)
    else $error("aging removed a static entry");
  a_flush_static: assert property (fl_st |-> !mem.we)
    else $error("flush cleared a static entry");
  a_static_write: assert property (mem.we && mem.wdata.is_static |-> m_chk)
    else $error("static entry written outside management");
  a_flush_len: assert property (take_fl |=> busy [*8])
    else $error("flush ended early");
endmodule

/* File: rtl/mlt_mem_if.sv */
`timescale 1ns/1ns
`include "mlt_defines.svh"
interface mlt_mem_if;
  logic [`MLT_AW-1:0] addr;
  logic we;
  mlt_pkg::mlt_entry_t wdata;
  mlt_pkg::mlt_entry_t rdata;
  modport ctl (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface

/* File: rtl/mlt_pkg.sv */
`include "mlt_defines.svh"
package mlt_pkg;
  typedef struct packed {
    logic valid;
    logic is_static;
    logic [47:0] mac;
    logic [11:0] vlan;
    logic [`MLT_PW-1:0] port;
    logic [11:0] stamp;
  } mlt_entry_t;

  typedef enum logic [1:0] {
    ACT_UNI,
    ACT_MCAST,
    ACT_FLOOD,
    ACT_DROP
  } mlt_act_t;

  typedef enum logic {
    MG_ADD,
    MG_DEL
  } mlt_mg_op_t;
endpackage

/* File: rtl/mlt_table_ram.sv */
`timescale 1ns/1ns
`include "mlt_defines.svh"
module mlt_table_ram (
  // clock
  input logic clock,
  // table port
  mlt_mem_if.mem m
);
  mlt_pkg::mlt_entry_t ram [0:(1<<`MLT_AW)-1];

  // contents are not reset: static entries must outlive a restart
  always_ff @(posedge clock)
  begin
    if (m.we)
    begin
      ram[m.addr] <= m.wdata;
    end
    m.rdata <= ram[m.addr];
  end
endmodule

/* File: testbench/mlt_port_model.sv */
`timescale 1ns/1ns
`include "mlt_defines.svh"
module mlt_port_model (
  // clock
  input logic clock,
  // lookup request
  output logic lk_valid,
  input logic lk_ready,
  output logic [47:0] lk_dst,
  output logic [47:0] lk_src,
  output logic [11:0] lk_vlan,
  output logic [`MLT_PW-1:0] lk_port,
  // lookup result
  input logic res_valid,
  input mlt_pkg::mlt_act_t res_act,
  input logic [`MLT_PORTS-1:0] res_mask
);
  initial
  begin
    lk_valid = 1'b0;
    lk_dst = 48'h0;
    lk_src = 48'h0;
    lk_vlan = 12'h0;
    lk_port = 2'h0;
  end

  // holds the frame header until taken; released lines show the inverse
  task automatic send(input logic [47:0] d, input logic [47:0] s, input logic [11:0] v,
    input logic [1:0] p, output int lat, output mlt_pkg::mlt_act_t a, output logic [3:0] m);
    int n;
    begin
      @(posedge clock);
      #1;
      lk_valid = 1'b1;
      lk_dst = d;
      lk_src = s;
      lk_vlan = v;
      lk_port = p;
      n = 0;
      @(negedge clock);
      while (lk_ready !== 1'b1 && n < 300)
      begin
        n++;
        @(negedge clock);
      end
      @(posedge clock);
      #1;
      lk_valid = 1'b0;
      lk_dst = ~d;
      lk_src = ~s;
      lk_vlan = ~v;
      lk_port = ~p;
      lat = 0;
      @(negedge clock);
      while (res_valid !== 1'b1 && lat < 10)
      begin
        lat++;
        @(negedge clock);
      end
      a = res_act;
      m = res_mask;
    end
  endtask
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/1ns
`include "mlt_defines.svh"
module testbench;
  logic clock;
  logic rst;
  logic lk_valid;
  logic lk_ready;
  logic [47:0] lk_dst;
  logic [47:0] lk_src;
  logic [11:0] lk_vlan;
  logic [1:0] lk_port;
  logic res_valid;
  mlt_pkg::mlt_act_t res_act;
  logic [3:0] res_mask;
  logic mg_valid;
  logic mg_ready;
  mlt_pkg::mlt_mg_op_t mg_op;
  logic [47:0] mg_mac;
  logic [11:0] mg_vlan;
  logic [1:0] mg_port;
  logic mg_done;
  logic mg_ok;
  logic learn_en;
  logic [11:0] age_time;
  logic [13:0] learn_limit;
  logic card_rst;
  logic busy;
  logic [13:0] dyn_count;
  logic [4:0] static_count;
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;
  localparam logic [47:0] mac_a = 48'h020000000001;
  localparam logic [47:0] mac_b = 48'h020000000002;
  localparam logic [47:0] mac_c = 48'h020000000003;
  localparam logic [47:0] mac_d = 48'h020000000004;
  localparam logic [47:0] mac_s = 48'h0200000000a5;
  localparam logic [47:0] mac_g = 48'h010000000077;

  mlt_fwd_table #(.CYC_PER_SEC(50)) mlt_fwd_table_i (.clock, .rst, .lk_valid, .lk_ready,
    .lk_dst, .lk_src, .lk_vlan, .lk_port, .res_valid, .res_act, .res_mask, .mg_valid,
    .mg_ready, .mg_op, .mg_mac, .mg_vlan, .mg_port, .mg_done, .mg_ok, .learn_en, .age_time,
    .learn_limit, .card_rst, .busy, .dyn_count, .static_count);

  mlt_port_model mlt_port_model_i (.clock, .lk_valid, .lk_ready, .lk_dst, .lk_src, .lk_vlan,
    .lk_port, .res_valid, .res_act, .res_mask);

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic summarize;
    begin
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      fails++;
      summarize();
    end
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    begin
      n_tests++;
      if (seen !== exp)
      begin
        fails++;
        $display("unexpected %s expected %0h seen %0h", name, exp, seen);
      end
    end
  endtask

  task automatic lk(input logic [47:0] d, input logic [47:0] s, input logic [11:0] v,
    input logic [1:0] p, input mlt_pkg::mlt_act_t ea, input logic [3:0] em);
    int lat;
    mlt_pkg::mlt_act_t a;
    logic [3:0] m;
    begin
      mlt_port_model_i.send(d, s, v, p, lat, a, m);
      chk("res_lat", 16'(lat), 16'h1);
      chk("res_act", 16'(a), 16'(ea));
      chk("res_mask", 16'(m), 16'(em));
    end
  endtask

  task automatic mg(input mlt_pkg::mlt_mg_op_t op, input logic [47:0] a, input logic [11:0] v,
    input logic [1:0] p, input logic ok);
    int n;
    begin
      @(posedge clock);
      #1;
      mg_valid = 1'b1;
      mg_op = op;
      mg_mac = a;
      mg_vlan = v;
      mg_port = p;
      n = 0;
      @(negedge clock);
      while (mg_ready !== 1'b1 && n < 300)
      begin
        n++;
        @(negedge clock);
      end
      @(posedge clock);
      #1;
      mg_valid = 1'b0;
      mg_mac = ~a;
      mg_vlan = ~v;
      n = 0;
      @(negedge clock);
      while (mg_done !== 1'b1 && n < 10)
      begin
        n++;
        @(negedge clock);
      end
      chk("mg_lat", 16'(n), 16'h1);
      chk("mg_ok", 16'(mg_ok), 16'(ok));
    end
  endtask

  // counts settle one edge after the result strobe
  task automatic counts(input logic [13:0] d, input logic [4:0] s);
    begin
      @(negedge clock);
      chk("dyn_count", 16'(dyn_count), 16'(d));
      chk("static_count", 16'(static_count), 16'(s));
    end
  endtask

  task automatic wait_idle;
    int n;
    begin
      n = 0;
      while (busy !== 1'b0 && n < 20000)
      begin
        n++;
        @(negedge clock);
      end
      chk("busy", 16'(busy), 16'h0);
    end
  endtask

  task automatic t_flood_learn;
    begin
      lk(mac_b, mac_a, 12'h005, 2'h1, mlt_pkg::ACT_FLOOD, 4'hd);
      lk(mac_a, mac_b, 12'h005, 2'h2, mlt_pkg::ACT_UNI, 4'h2);
      counts(14'h0002, 5'h00);
      lk(mac_a, mac_g, 12'h006, 2'h0, mlt_pkg::ACT_FLOOD, 4'he);
      lk(48'hffffffffffff, mac_g, 12'h005, 2'h3, mlt_pkg::ACT_FLOOD, 4'h7);
      $display("t_flood_learn done");
    end
  endtask

  task automatic t_mcast;
    begin
      lk(mac_g, mac_g, 12'h005, 2'h0, mlt_pkg::ACT_DROP, 4'h0);
      mg(mlt_pkg::MG_ADD, mac_g, 12'h005, 2'h3, 1'b1);
      lk(mac_g, mac_g, 12'h005, 2'h0, mlt_pkg::ACT_MCAST, 4'h8);
      counts(14'h0002, 5'h01);
      $display("t_mcast done");
    end
  endtask

  task automatic t_limit;
    begin
      learn_en = 1'b0;
      lk(mac_b, mac_c, 12'h005, 2'h1, mlt_pkg::ACT_UNI, 4'h4);
      counts(14'h0002, 5'h01);
      learn_en = 1'b1;
      learn_limit = 14'h0002;
      lk(mac_b, mac_d, 12'h005, 2'h1, mlt_pkg::ACT_UNI, 4'h4);
      counts(14'h0002, 5'h01);
      lk(mac_d, mac_g, 12'h005, 2'h2, mlt_pkg::ACT_FLOOD, 4'hb);
      learn_limit = 14'h0064;
      $display("t_limit done");
    end
  endtask

  task automatic t_static;
    begin
      mg(mlt_pkg::MG_DEL, mac_a, 12'h005, 2'h0, 1'b0);
      mg(mlt_pkg::MG_ADD, mac_s, 12'h005, 2'h0, 1'b1);
      lk(mac_s, mac_s, 12'h005, 2'h2, mlt_pkg::ACT_UNI, 4'h1);
      lk(mac_s, mac_g, 12'h005, 2'h1, mlt_pkg::ACT_UNI, 4'h1);
      for (int i = 0; i < 28; i++)
        mg(mlt_pkg::MG_ADD, 48'h0a0000000040 + 48'(i), 12'h009, 2'h1, 1'b1);
      counts(14'h0002, 5'h1e);
      mg(mlt_pkg::MG_ADD, 48'h0a00000000ff, 12'h009, 2'h1, 1'b0);
      mg(mlt_pkg::MG_DEL, 48'h0a0000000040, 12'h009, 2'h1, 1'b1);
      counts(14'h0002, 5'h1d);
      $display("t_static done");
    end
  endtask

  task automatic t_card;
    begin
      @(posedge clock);
      #1;
      card_rst = 1'b1;
      @(posedge clock);
      #1;
      card_rst = 1'b0;
      repeat (4) @(negedge clock);
      chk("busy", 16'(busy), 16'h1);
      wait_idle();
      counts(14'h0000, 5'h1d);
      lk(mac_s, mac_g, 12'h005, 2'h1, mlt_pkg::ACT_UNI, 4'h1);
      lk(mac_a, mac_g, 12'h005, 2'h1, mlt_pkg::ACT_FLOOD, 4'hd);
      $display("t_card done");
    end
  endtask

  task automatic t_age;
    begin
      age_time = 12'h001;
      lk(48'hffffffffffff, mac_a, 12'h005, 2'h1, mlt_pkg::ACT_FLOOD, 4'hd);
      counts(14'h0001, 5'h1d);
      repeat (34000) @(posedge clock);
      lk(mac_a, mac_g, 12'h005, 2'h2, mlt_pkg::ACT_FLOOD, 4'hb);
      counts(14'h0000, 5'h1d);
      lk(mac_s, mac_g, 12'h005, 2'h2, mlt_pkg::ACT_UNI, 4'h1);
      $display("t_age done");
    end
  endtask

  initial
  begin
    rst = 1'b1;
    mg_valid = 1'b0;
    mg_op = mlt_pkg::MG_ADD;
    mg_mac = 48'h0;
    mg_vlan = 12'h0;
    mg_port = 2'h0;
    learn_en = 1'b1;
    age_time = 12'h000;
    learn_limit = 14'h0064;
    card_rst = 1'b0;
    repeat (4) @(posedge clock);
    #1;
    rst = 1'b0;
    @(negedge clock);
    wait_idle();
    chk("dyn_count", 16'(dyn_count), 16'h0);
    t_flood_learn();
    t_mcast();
    t_limit();
    t_static();
    t_card();
    t_age();
    summarize();
  end
endmodule
